// ---- verilog/bpms_supervisor.sv ----
`timescale 1ns/100ps
// What this block does
// [R1] high-side stays off while valley current sits above trip level
// [R2] feedback under 68% for 1 ms latches both drivers off
// [R3] undervoltage timing armed only after soft-start finishes
// [R4] feedback over 120% latches high-side off, low-side on to negative limit
// [R5] at negative limit low-side off, high-side on for minimum on-time, repeat
// [R6] discharge repeats until under-threshold for 1 ms, then high off, low on
// [R7] latched faults cleared only by supply reset or enable re-toggle
// [R8] feedback 8% high forces low-side on past zero current, no fault
// [R9] out-of-bounds low-side conduction ends on negative current limit
// [R10] supply lockout stops switching, resumes on on-threshold, no latch
// [R11] overtemperature stops switching, resumes after cooling, no latch
// [R12] mode grounded: auto-skip, low-side off on zero current
// [R13] on-time equal in discontinuous and continuous conduction
// [R14] mode tied to power good: continuous conduction at light load
// [R15] auto-skip adapts zero-cross timing against late or early detection
// [R16] feedback recovery before 1 ms restarts the undervoltage timer
module bpms_supervisor
	import bpms_pkg::*;
#(
	parameter int UV_DELAY_CYCLES = UV_DELAY_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// control pins and status
	input wire logic enable_i,
	input wire logic soft_start_done_i,
	input wire logic mode_to_power_good_i,
	input wire logic power_good_output_i,
	input wire logic on_time_req_i,
	// feedback comparators
	input wire logic fb_under_uv_i,
	input wire logic fb_over_ov_i,
	input wire logic fb_over_oob_i,
	// current comparators
	input wire logic valley_current_limit_i,
	input wire logic negative_current_limit_i,
	input wire logic zero_cross_i,
	input wire logic zc_late_i,
	input wire logic zc_early_i,
	// temperature and supply comparators
	input wire logic temp_over_i,
	input wire logic temp_cooled_i,
	input wire logic supply_above_off_i,
	input wire logic supply_above_on_i,
	// gate-drive commands
	output logic hs_on_o,
	output logic ls_on_o,
	// status
	output logic undervoltage_protect_o,
	output logic overvoltage_protect_o,
	output logic out_of_bounds_discharge_o,
	output logic skip_mode_o,
	output logic [TRIM_W-1:0] zc_trim_o
);
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] s;
	bpms_state_t st;
	bpms_state_t next_st;
	logic supply_ok;
	logic too_hot;
	logic allow;
	logic uv_armed;
	logic [UV_CNT_W-1:0] uv_cnt;
	logic uv_done;
	logic [ON_CNT_W-1:0] on_cnt;
	logic hs_phase;
	logic pulse_used;
	logic ls_stop;
	logic skip;
	logic next_hs;
	logic next_ls;

	// every comparator and pin is asynchronous to the timing clock; order follows the S_ positions, top bit first
	assign raw = {zc_early_i, zc_late_i, on_time_req_i, power_good_output_i, mode_to_power_good_i, soft_start_done_i,
		supply_above_on_i, supply_above_off_i, temp_cooled_i, temp_over_i, zero_cross_i, negative_current_limit_i,
		valley_current_limit_i, fb_over_oob_i, fb_over_ov_i, fb_under_uv_i, enable_i};
	bpms_sync #(.W(SYNC_W)) u_sync (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .async_i(raw), .sync_o(s));

	// supply and thermal hysteresis, self-clearing
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			supply_ok <= 1'b0;
			too_hot <= 1'b0;
		end
		else
		begin
			if (!s[S_SOFF])
				supply_ok <= 1'b0; // [R10]
			else if (s[S_SON])
				supply_ok <= 1'b1; // [R10]
			if (s[S_HOT])
				too_hot <= 1'b1; // [R11]
			else if (s[S_COOL])
				too_hot <= 1'b0; // [R11]
		end
	end

	assign allow = s[S_EN] && supply_ok && !too_hot;
	// forced continuous only once power good is up
	assign skip = !(s[S_MPG] && s[S_PG]); // [R12] [R14]
	assign uv_done = s[S_UV] && (uv_cnt == UV_CNT_W'(UV_DELAY_CYCLES - 1));

	// protection sequencer
	always_comb
	begin
		next_st = st;
		if (!s[S_EN])
			next_st = ST_OFF; // [R7]
		else
		begin
			case (st)
				ST_OFF:
					if (allow)
						next_st = ST_RUN;
				ST_RUN:
					if (!allow)
						next_st = ST_OFF; // [R10] [R11]
					else if (s[S_OV])
						next_st = ST_OV_DISCH; // [R4]
					else if (uv_armed && uv_done)
						next_st = ST_UV_LATCH; // [R2]
				ST_OV_DISCH:
					if (uv_done)
						next_st = ST_OV_LATCH; // [R6]
					else if (s[S_NOCL])
						next_st = ST_OV_PULSE; // [R5]
				ST_OV_PULSE:
					if (uv_done)
						next_st = ST_OV_LATCH; // [R6]
					else if (on_cnt == ON_CNT_W'(MIN_ON_CYC - 1))
						next_st = ST_OV_DISCH; // [R5]
				ST_UV_LATCH, ST_OV_LATCH:
					next_st = st; // [R7] held until reset or enable low
				default:
					next_st = ST_OFF;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st <= ST_OFF;
		else
			st <= next_st;
	end

	// minimum on-time counter for discharge pulses
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			on_cnt <= '0;
		else if (st == ST_OV_PULSE)
			on_cnt <= on_cnt + 1'b1; // [R5]
		else
			on_cnt <= '0;
	end

	// undervoltage arming and delay; drops back to zero on recovery
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			uv_armed <= 1'b0;
			uv_cnt <= '0;
		end
		else
		begin
			if (st == ST_OFF)
				uv_armed <= 1'b0;
			else if (s[S_SSD])
				uv_armed <= 1'b1; // [R3]
			if (!s[S_UV] || uv_done)
				uv_cnt <= '0; // [R16]
			else if ((st == ST_RUN && uv_armed) || st == ST_OV_DISCH || st == ST_OV_PULSE)
				uv_cnt <= uv_cnt + 1'b1; // [R2] [R3] [R6]
			else
				uv_cnt <= '0;
		end
	end
	// switching cycle: on-time comes from the loop unchanged in either conduction mode
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			hs_phase <= 1'b0;
			pulse_used <= 1'b0;
			ls_stop <= 1'b0;
		end
		else if (st != ST_RUN)
		begin
			hs_phase <= 1'b0;
			pulse_used <= 1'b0;
			ls_stop <= 1'b0;
		end
		else if (hs_phase)
		begin
			if (!s[S_TON])
				hs_phase <= 1'b0; // [R13]
		end
		else
		begin
			if (!s[S_TON])
				pulse_used <= 1'b0;
			if (s[S_TON] && !pulse_used && !s[S_OCL])
			begin
				hs_phase <= 1'b1; // [R1] [R13]
				pulse_used <= 1'b1;
				ls_stop <= 1'b0;
			end
			else if (s[S_NOCL])
				ls_stop <= 1'b1; // [R9]
			else if (skip && s[S_ZC] && !s[S_OOB])
				ls_stop <= 1'b1; // [R8] [R12]
		end
	end
	// adaptive zero-cross trim; late detection moves the trip earlier
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			zc_trim_o <= TRIM_RST;
		else if (skip && st == ST_RUN && !hs_phase && s[S_ZC])
		begin
			if (s[S_LATE] && zc_trim_o != TRIM_MAX)
				zc_trim_o <= zc_trim_o + 1'b1; // [R15]
			else if (s[S_EARLY] && !s[S_LATE] && zc_trim_o != TRIM_MIN)
				zc_trim_o <= zc_trim_o - 1'b1; // [R15]
		end
	end
	// gate commands; hs and ls are never requested together
	assign next_hs = (st == ST_RUN && hs_phase) || st == ST_OV_PULSE;
	assign next_ls = (st == ST_RUN && !hs_phase && !ls_stop) || st == ST_OV_DISCH || st == ST_OV_LATCH; // [R4] [R6]
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			hs_on_o <= 1'b0;
			ls_on_o <= 1'b0;
			undervoltage_protect_o <= 1'b0;
			overvoltage_protect_o <= 1'b0;
			out_of_bounds_discharge_o <= 1'b0;
			skip_mode_o <= 1'b1;
		end
		else
		begin
			hs_on_o <= next_hs;
			ls_on_o <= next_ls;
			undervoltage_protect_o <= (st == ST_UV_LATCH);
			overvoltage_protect_o <= (st == ST_OV_LATCH);
			out_of_bounds_discharge_o <= (st == ST_RUN) && s[S_OOB]; // [R8]
			skip_mode_o <= skip;
		end
	end
	// checks
	sequence s_ov_discharge;
		st == ST_OV_DISCH ##1 (ls_on_o && !hs_on_o);
	endsequence
	sequence s_min_pulse;
		(st == ST_OV_PULSE && hs_on_o) ##1 (st != ST_OV_PULSE && hs_on_o) ##1 !hs_on_o;
	endsequence
	a_valley_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R1]
		(st == ST_RUN && !hs_phase && s[S_OCL]) |=> !hs_phase)
		else $error("high-side started above valley limit");
	a_uv_latch_off: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R2]
		(st == ST_UV_LATCH && s[S_EN]) |=> (!hs_on_o && !ls_on_o && st == ST_UV_LATCH))
		else $error("undervoltage latch not holding drivers off");
	a_uv_unarmed: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R3]
		(st == ST_RUN && !uv_armed) |=> (uv_cnt == '0 || $past(uv_armed) || st != ST_RUN))
		else $error("undervoltage timer ran before soft-start end");
	a_ov_entry: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R4]
		(st == ST_RUN && allow && s[S_OV]) |=> s_ov_discharge)
		else $error("overvoltage did not start discharge");
	a_ov_pulse: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R5]
		(st == ST_OV_DISCH && s[S_EN] && s[S_NOCL] && !uv_done
			##1 (s[S_EN] && !uv_done)[*2]) |=> s_min_pulse)
		else $error("minimum on-time pulse wrong length");
	a_ov_final: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R6]
		(st == ST_OV_DISCH && s[S_EN] && uv_done) |=> st == ST_OV_LATCH ##1 (ls_on_o && !hs_on_o))
		else $error("discharge did not end in low-side latch");
	a_en_clear: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R7]
		!s[S_EN] |=> (st == ST_OFF ##1 (!hs_on_o && !overvoltage_protect_o && !undervoltage_protect_o)))
		else $error("enable low did not clear the fault");
	a_oob_nocl: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R9]
		(st == ST_RUN && s[S_EN] && allow && !s[S_OV] && !hs_phase && s[S_NOCL] && !uv_done)
			|=> ##1 !ls_on_o)
		else $error("low-side kept on past negative limit");
	a_lockout: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R10] [R11]
		(st == ST_RUN && (!supply_ok || too_hot)) |=> st == ST_OFF ##1 (!hs_on_o && !ls_on_o))
		else $error("switching continued under lockout");
	a_uv_restart: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [R16]
		!s[S_UV] |=> uv_cnt == '0)
		else $error("undervoltage timer not restarted");
endmodule // bpms_supervisor

// ---- inc/bpms_pkg.sv ----
package bpms_pkg;
	// timing base
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int UV_DELAY_US = 1000;
	localparam int MIN_ON_NS = 120;
	// least time: round up to whole cycles
	localparam int UV_DELAY_CYC = UV_DELAY_US * CLK_MHZ;
	localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
	// counter widths
	localparam int UV_CNT_W = 16;
	localparam int ON_CNT_W = 4;
	localparam int TRIM_W = 4;
	localparam logic [TRIM_W-1:0] TRIM_RST = 4'h8;
	localparam logic [TRIM_W-1:0] TRIM_MAX = 4'hf;
	localparam logic [TRIM_W-1:0] TRIM_MIN = 4'h0;
	// synchronised input bit positions
	localparam int S_EN = 0;
	localparam int S_UV = 1;
	localparam int S_OV = 2;
	localparam int S_OOB = 3;
	localparam int S_OCL = 4;
	localparam int S_NOCL = 5;
	localparam int S_ZC = 6;
	localparam int S_HOT = 7;
	localparam int S_COOL = 8;
	localparam int S_SOFF = 9;
	localparam int S_SON = 10;
	localparam int S_SSD = 11;
	localparam int S_MPG = 12;
	localparam int S_PG = 13;
	localparam int S_TON = 14;
	localparam int S_LATE = 15;
	localparam int S_EARLY = 16;
	localparam int SYNC_W = 17;
	// supervisor states
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_RUN = 3'h1,
		ST_OV_DISCH = 3'h2,
		ST_OV_PULSE = 3'h3,
		ST_UV_LATCH = 3'h4,
		ST_OV_LATCH = 3'h5
	} bpms_state_t;
endpackage

// ---- verilog/bpms_sync.sv ----
`timescale 1ns/100ps
// two-stage synchroniser bank, one pair per input bit
module bpms_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			logic meta;
			// first stage feeds only the second stage
			always_ff @(posedge ref_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					meta <= 1'b0;
					sync_o[g] <= 1'b0;
				end
				else
				begin
					meta <= async_i[g];
					sync_o[g] <= meta;
				end
			end
		end
	endgenerate
endmodule // bpms_sync

// ---- tb/bpms_power_stage.sv ----
`timescale 1ns/100ps
// behavioural power stage: inductor current and its analogue comparators
module bpms_power_stage (
	// clock
	input wire logic ref_clk_i,
	// gate commands and test overload
	input wire logic hs_on_i,
	input wire logic ls_on_i,
	input wire logic over_load_i,
	// comparator levels
	output logic valley_current_limit_o,
	output logic negative_current_limit_o,
	output logic zero_cross_o
);
	int cur = 0;
	// rises twice as fast as it falls, so a discharge takes several cycles
	always @(posedge ref_clk_i)
	begin
		if (hs_on_i)
			cur <= cur + 2;
		else if (ls_on_i)
			cur <= cur - 1;
	end
	// comparators are unclocked levels, like the real analogue ones
	assign valley_current_limit_o = over_load_i || (cur > 40);
	assign negative_current_limit_o = (cur <= -6);
	assign zero_cross_o = (cur <= 0);
endmodule // bpms_power_stage

// ---- tb/test_buck_protection_mode_supervisor.sv ----
`timescale 1ns/100ps
// bench for the protection and mode supervisor
module test_buck_protection_mode_supervisor
	import bpms_pkg::*;
;
	logic ref_clk_i, arst_n_i, en, ss, mode, pg, req, f_uv, f_ov, f_oob, late, early;
	logic hot, cool, s_off, s_on, ovl, vcl, ncl, zc, hs, ls, undervoltage_protect, overvoltage_protect, out_of_bounds_discharge, skip;
	logic [TRIM_W-1:0] trim;
	int n_errors = 0;
	int n_compared = 0;
	bpms_supervisor #(.UV_DELAY_CYCLES(20)) bpms_supervisor_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.enable_i(en), .soft_start_done_i(ss), .mode_to_power_good_i(mode), .power_good_output_i(pg),
		.on_time_req_i(req), .fb_under_uv_i(f_uv), .fb_over_ov_i(f_ov), .fb_over_oob_i(f_oob),
		.valley_current_limit_i(vcl), .negative_current_limit_i(ncl), .zero_cross_i(zc), .zc_late_i(late),
		.zc_early_i(early), .temp_over_i(hot), .temp_cooled_i(cool), .supply_above_off_i(s_off),
		.supply_above_on_i(s_on), .hs_on_o(hs), .ls_on_o(ls), .undervoltage_protect_o(undervoltage_protect),
		.overvoltage_protect_o(overvoltage_protect), .out_of_bounds_discharge_o(out_of_bounds_discharge), .skip_mode_o(skip), .zc_trim_o(trim));
	bpms_power_stage bpms_power_stage_i (.ref_clk_i(ref_clk_i), .hs_on_i(hs), .ls_on_i(ls),
		.over_load_i(ovl), .valley_current_limit_o(vcl), .negative_current_limit_o(ncl), .zero_cross_o(zc));
	// 25 MHz clock
	initial
	begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	task cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task test_done;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one on-time request, then long enough for the low-side phase to end
	task pulse(output int n, output logic l);
		n = 0;
		l = 1'b0;
		req = 1'b1;
		repeat (6)
		begin
			cyc(1);
			n += (hs === 1'b1);
		end
		req = 1'b0;
		repeat (30)
		begin
			cyc(1);
			n += (hs === 1'b1);
			l |= (ls === 1'b1);
		end
	endtask
	task t_valley;
		int n;
		logic l;
		ovl = 1'b1;
		req = 1'b1;
		repeat (8)
		begin
			cyc(1);
			chk("hs_blocked", 0, hs);
		end
		req = 1'b0;
		ovl = 1'b0;
		cyc(4);
		pulse(n, l);
		chk("hs_released", 1, n > 0);
	endtask
	task t_modes;
		int n1, n2;
		logic l;
		logic [3:0] t;
		pulse(n1, l);
		chk("skip_flag", 1, skip);
		chk("ls_used", 1, l);
		chk("ls_off_zc", 0, ls);
		mode = 1'b1;
		pg = 1'b1;
		cyc(5);
		chk("skip_flag", 0, skip);
		pulse(n2, l);
		chk("on_time", n1[3:0], n2[3:0]);
		chk("forced_continuous_mode_ls_neg", 1, bpms_power_stage_i.cur <= -6);
		mode = 1'b0;
		pg = 1'b0;
		late = 1'b1;
		cyc(5);
		pulse(n1, l);
		chk("trim_up", 1, trim > 4'h8);
		t = trim;
		late = 1'b0;
		early = 1'b1;
		pulse(n1, l);
		chk("trim_down", 1, trim < t);
		early = 1'b0;
	endtask
	task t_oob;
		logic deep;
		deep = 1'b0;
		f_oob = 1'b1;
		cyc(5);
		chk("oob_flag", 1, out_of_bounds_discharge);
		req = 1'b1;
		cyc(6);
		req = 1'b0;
		repeat (30)
		begin
			cyc(1);
			deep |= (ls === 1'b1 && bpms_power_stage_i.cur <= -6);
		end
		chk("ls_past_zero", 1, deep);
		chk("ls_neg_stop", 0, ls);
		chk("oob_no_fault", 0, {undervoltage_protect, overvoltage_protect});
		f_oob = 1'b0;
		cyc(5);
		chk("oob_cleared", 0, out_of_bounds_discharge);
	endtask
	task t_nonlatch;
		int n;
		logic l;
		for (int k = 0; k < 2; k++)
		begin
			if (k == 0)
				{s_off, s_on} = 2'b00;
			else
				{hot, cool} = 2'b10;
			cyc(4);
			pulse(n, l);
			chk("halt_sw", 0, {n != 0, l});
			{s_off, s_on, hot, cool} = 4'b1101;
			cyc(4);
			pulse(n, l);
			chk("resume_sw", 1, n != 0);
		end
	endtask
	task t_uv;
		int n;
		logic l;
		f_uv = 1'b1;
		cyc(40);
		chk("uv_unarmed", 0, undervoltage_protect);
		f_uv = 1'b0;
		ss = 1'b1;
		cyc(4);
		f_uv = 1'b1;
		cyc(12);
		f_uv = 1'b0;
		cyc(4);
		f_uv = 1'b1;
		cyc(15);
		chk("uv_restart", 0, undervoltage_protect);
		cyc(10);
		chk("uv_latch", 4'h4, {undervoltage_protect, hs, ls});
		f_uv = 1'b0;
		pulse(n, l);
		chk("uv_held", 4'h4, {undervoltage_protect, n != 0, l});
		en = 1'b0;
		cyc(4);
		en = 1'b1;
		cyc(6);
		chk("uv_cleared", 0, undervoltage_protect);
	endtask
	task t_ov;
		int r, w;
		r = 0;
		w = 0;
		f_ov = 1'b1;
		cyc(5);
		chk("ov_gates", 4'h1, {hs, ls});
		repeat (60)
		begin
			cyc(1);
			if (hs === 1'b1)
				w++;
			else if (w != 0)
			begin
				r++;
				chk("ov_pulse_w", 4'(MIN_ON_CYC), w[3:0]);
				w = 0;
			end
		end
		chk("ov_repeat", 1, r >= 2);
		f_ov = 1'b0;
		f_uv = 1'b1;
		cyc(15);
		chk("ov_hold", 0, overvoltage_protect);
		cyc(15);
		chk("ov_latch", 4'h5, {overvoltage_protect, hs, ls});
		f_uv = 1'b0;
		cyc(10);
		chk("ov_held", 1, overvoltage_protect);
		arst_n_i = 1'b0;
		cyc(3);
		arst_n_i = 1'b1;
		cyc(8);
		chk("ov_cleared", 0, overvoltage_protect);
	endtask
	// hang guard, far beyond the roughly 670 cycles the tests need
	initial
	begin
		#200000;
		n_errors++;
		test_done;
	end
	initial
	begin
		{arst_n_i, en, ss, mode, pg, req, f_uv, f_ov, f_oob, late, early} = 11'h200;
		{hot, cool, s_off, s_on, ovl} = 5'b01110;
		cyc(10);
		chk("rst_out", 4'h1, {hs, ls, undervoltage_protect, skip}); // reset
		chk("rst_trim", 4'h8, trim); // reset
		arst_n_i = 1'b1;
		cyc(8);
		t_valley;
		t_modes;
		t_oob;
		t_nonlatch;
		t_uv;
		t_ov;
		test_done;
	end
endmodule // test_buck_protection_mode_supervisor
